// *** logic/tcb_trace_capture.sv ***
// Notes on behaviour
// - frames read back by index relative to trigger; trigger frame is zero
// - each frame tagged fetch, external write or external read
// - each frame holds interrupt level, zero in main program
// - each frame holds bus address and data byte
// - each frame holds full first and third port states
// - each frame holds both sync probes and both extra probes
// - post-trigger counter counts frames stored after trigger
// - pre-trigger counter counts frames stored before trigger
// - loop counter counts trigger passes, readable by host
// - status shows cond a, cond b, triggered, loop done/stopped, done
// - stop command halts capture, shows stopped, emulation unaffected
// - resume command restarts capture after a stop
// - capture starts by itself when emulation starts
// - buffer wraps, keeping the last 16K or 4K frames
// - capture ends when post frames fill, or on breakpoint or escape
// - post-trigger setting adjustable, default half the 16K buffer; the 4K setting masks that default to zero
`timescale 1ns/100ps
module tcb_trace_capture
    import tcb_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [TCB_AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [TCB_AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic emu_run,
    input wire logic cyc_valid,
    input wire tcb_cyc_e cyc_type,
    input wire logic [15:0] cyc_addr,
    input wire logic [7:0] cyc_data,
    input wire logic [2:0] int_level,
    input wire logic [7:0] first_io_port_state,
    input wire logic [7:0] third_io_port_state,
    input wire logic sync_probe_a,
    input wire logic sync_probe_b,
    input wire logic extra_probe_a,
    input wire logic extra_probe_b,
    input wire logic trig_in,
    input wire logic cond_a_in,
    input wire logic cond_b_in,
    input wire logic break_in,
    output logic capture_active,
    output logic irq
);
    function automatic logic hit(input logic [TCB_AXI_AW-1:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // pod probes come from pins: two flops before use
    logic [3:0] probe_meta_reg;
    logic [3:0] probe_sync_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            probe_meta_reg <= 4'h0;
            probe_sync_reg <= 4'h0;
        end else begin
            probe_meta_reg <= {extra_probe_b, extra_probe_a, sync_probe_b, sync_probe_a};
            probe_sync_reg <= probe_meta_reg;
        end
    end

    // ---------------- axi4-lite slave ----------------
    logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
    logic [TCB_AXI_AW-1:0] aw_addr_reg, aw_addr_next, ar_addr;
    logic [31:0] w_data_reg, w_data_next, rd_mux, rdata_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_next, rvalid_next, arready_next, wr_hit, rd_hit;
    logic [1:0] bresp_next, rresp_next;
    logic do_write;

    assign do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;

    always_comb begin
        aw_full_next = aw_full_reg;
        aw_addr_next = aw_addr_reg;
        w_full_next = w_full_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = s_axi_bvalid;
        bresp_next = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (do_write) begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = wr_hit ? TCB_RESP_OKAY : TCB_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        rvalid_next = s_axi_rvalid;
        rdata_next = s_axi_rdata;
        rresp_next = s_axi_rresp;
        arready_next = s_axi_arready;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rdata_next = rd_mux;
            rresp_next = rd_hit ? TCB_RESP_OKAY : TCB_RESP_SLVERR;
            arready_next = 1'b0;
        end else if (s_axi_rvalid && s_axi_rready) begin
            rvalid_next = 1'b0;
            arready_next = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= TCB_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= TCB_RESP_OKAY;
        end else begin
            aw_full_reg <= aw_full_next;
            aw_addr_reg <= aw_addr_next;
            w_full_reg <= w_full_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            s_axi_awready <= ~aw_full_next & ~bvalid_next;
            s_axi_wready <= ~w_full_next & ~bvalid_next;
            s_axi_bvalid <= bvalid_next;
            s_axi_bresp <= bresp_next;
            // arready first rises one cycle after reset release
            s_axi_arready <= arready_next | (~s_axi_arready & ~s_axi_rvalid & ~rvalid_next);
            s_axi_rvalid <= rvalid_next;
            s_axi_rdata <= rdata_next;
            s_axi_rresp <= rresp_next;
        end
    end

    assign ar_addr = s_axi_araddr;

    // ---------------- configuration ----------------
    logic [13:0] post_trigger_setting_reg, post_trigger_setting_next;
    logic [15:0] loop_setting_reg, loop_setting_next;
    logic [15:0] frame_sel_reg, frame_sel_next;
    logic small_cfg_reg, small_cfg_next;
    logic [TCB_EV_W-1:0] irq_mask_reg, irq_mask_next;
    logic [31:0] ctrl_word;
    logic trace_stop_cmd, trace_resume_cmd, escape_cmd;

    assign ctrl_word = (do_write && hit(aw_addr_reg, TCB_OFF_CTRL)) ? (w_data_reg & {{24{1'b0}}, {8{w_strb_reg[0]}}}) : 32'h0;
    assign trace_stop_cmd = ctrl_word[TCB_CTRL_STOP];
    assign trace_resume_cmd = ctrl_word[TCB_CTRL_RESUME];
    assign escape_cmd = ctrl_word[TCB_CTRL_ESCAPE];

    always_comb begin
        logic [31:0] m;
        m = 32'h0;
        post_trigger_setting_next = post_trigger_setting_reg;
        loop_setting_next = loop_setting_reg;
        frame_sel_next = frame_sel_reg;
        small_cfg_next = small_cfg_reg;
        irq_mask_next = irq_mask_reg;
        if (do_write) begin
            if (hit(aw_addr_reg, TCB_OFF_POST_SET)) begin
                m = merge({18'h0, post_trigger_setting_reg}, w_data_reg, w_strb_reg);
                post_trigger_setting_next = m[TCB_PTR_W-1:0];
            end
            if (hit(aw_addr_reg, TCB_OFF_LOOP_SET)) begin
                m = merge({16'h0, loop_setting_reg}, w_data_reg, w_strb_reg);
                loop_setting_next = m[15:0];
            end
            if (hit(aw_addr_reg, TCB_OFF_FRAME_SEL)) begin
                m = merge({16'h0, frame_sel_reg}, w_data_reg, w_strb_reg);
                frame_sel_next = m[15:0];
            end
            if (hit(aw_addr_reg, TCB_OFF_CTRL) && w_strb_reg[0]) begin
                small_cfg_next = w_data_reg[TCB_CTRL_SMALL];
            end
            if (hit(aw_addr_reg, TCB_OFF_IRQ_MASK) && w_strb_reg[0]) begin
                irq_mask_next = w_data_reg[TCB_EV_W-1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            post_trigger_setting_reg <= TCB_POST_DEFAULT;
            loop_setting_reg <= TCB_LOOP_DEFAULT;
            frame_sel_reg <= 16'h0;
            small_cfg_reg <= 1'b0;
            irq_mask_reg <= '0;
        end else begin
            post_trigger_setting_reg <= post_trigger_setting_next;
            loop_setting_reg <= loop_setting_next;
            frame_sel_reg <= frame_sel_next;
            small_cfg_reg <= small_cfg_next;
            irq_mask_reg <= irq_mask_next;
        end
    end

    // ---------------- trace engine ----------------
    tcb_state_e state_reg, state_next;
    logic [13:0] wr_ptr_reg, wr_ptr_next, trig_ptr_reg, trig_ptr_next;
    logic [13:0] pre_cnt_reg, pre_cnt_next, post_trigger_count_reg, post_trigger_count_next;
    logic [15:0] loop_cnt_reg, loop_cnt_next;
    logic cond_a_hit_reg, cond_a_hit_next, cond_b_hit_reg, cond_b_hit_next;
    logic triggered_reg, triggered_next, loop_done_reg, loop_done_next;
    logic emu_run_d_reg;
    logic [TCB_EV_W-1:0] irq_stat_reg, irq_stat_next, ev, irq_clr;
    logic [13:0] mask, post_limit;
    logic capturing, store, start, stop_req;
    tcb_frame_s cur_frame, rd_frame;

    assign mask = small_cfg_reg ? TCB_MASK_SMALL : TCB_MASK_FULL;
    assign post_limit = post_trigger_setting_reg & mask;
    assign start = emu_run & ~emu_run_d_reg;
    assign capturing = (state_reg == TCB_ST_PRE) || (state_reg == TCB_ST_POST);
    assign store = capturing & cyc_valid & ~start;
    assign stop_req = trace_stop_cmd | escape_cmd | break_in;

    always_comb begin
        cur_frame.cycle_type_tag = cyc_type;
        cur_frame.int_level = int_level;
        cur_frame.addr = cyc_addr;
        cur_frame.data = cyc_data;
        cur_frame.first_io_port_state = first_io_port_state;
        cur_frame.third_io_port_state = third_io_port_state;
        {cur_frame.extra_probe_b, cur_frame.extra_probe_a,
         cur_frame.sync_probe_b, cur_frame.sync_probe_a} = probe_sync_reg;
    end

    always_comb begin
        state_next = state_reg;
        wr_ptr_next = wr_ptr_reg;
        trig_ptr_next = trig_ptr_reg;
        pre_cnt_next = pre_cnt_reg;
        post_trigger_count_next = post_trigger_count_reg;
        loop_cnt_next = loop_cnt_reg;
        triggered_next = triggered_reg;
        loop_done_next = loop_done_reg;
        cond_a_hit_next = cond_a_hit_reg | (capturing & cond_a_in);
        cond_b_hit_next = cond_b_hit_reg | (capturing & cond_b_in);
        if (start) begin
            // emulation start re-arms the trace from an empty buffer
            state_next = TCB_ST_PRE;
            wr_ptr_next = 14'h0;
            trig_ptr_next = 14'h0;
            pre_cnt_next = 14'h0;
            post_trigger_count_next = 14'h0;
            loop_cnt_next = 16'h0;
            triggered_next = 1'b0;
            loop_done_next = 1'b0;
            cond_a_hit_next = 1'b0;
            cond_b_hit_next = 1'b0;
        end else begin
            unique case (state_reg)
                TCB_ST_IDLE: begin
                end
                TCB_ST_PRE: begin
                    if (stop_req) begin
                        state_next = TCB_ST_STOP;
                    end else if (store) begin
                        wr_ptr_next = (wr_ptr_reg + 14'h1) & mask;
                        if (trig_in) begin
                            loop_cnt_next = loop_cnt_reg + 16'h1;
                        end
                        if (trig_in && loop_cnt_reg >= loop_setting_reg) begin
                            trig_ptr_next = wr_ptr_reg;
                            triggered_next = 1'b1;
                            loop_done_next = 1'b1;
                            post_trigger_count_next = 14'h0;
                            state_next = (post_limit == 14'h0) ? TCB_ST_DONE : TCB_ST_POST;
                        end else if (pre_cnt_reg != mask) begin
                            pre_cnt_next = pre_cnt_reg + 14'h1;
                        end
                    end
                end
                TCB_ST_POST: begin
                    if (stop_req) begin
                        state_next = TCB_ST_STOP;
                    end else if (store) begin
                        wr_ptr_next = (wr_ptr_reg + 14'h1) & mask;
                        post_trigger_count_next = post_trigger_count_reg + 14'h1;
                        if (post_trigger_count_next == post_limit) begin
                            state_next = TCB_ST_DONE;
                        end
                    end
                end
                TCB_ST_STOP: begin
                    if (trace_resume_cmd) begin
                        state_next = triggered_reg ? TCB_ST_POST : TCB_ST_PRE;
                    end
                end
                TCB_ST_DONE: begin
                end
            endcase
        end
        ev = '0;
        ev[TCB_EV_COND_A] = capturing & cond_a_in;
        ev[TCB_EV_COND_B] = capturing & cond_b_in;
        ev[TCB_EV_TRIG] = triggered_next & ~triggered_reg;
        ev[TCB_EV_STOP] = (state_next == TCB_ST_STOP) && (state_reg != TCB_ST_STOP);
        ev[TCB_EV_DONE] = (state_next == TCB_ST_DONE) && (state_reg != TCB_ST_DONE);
        irq_clr = (do_write && hit(aw_addr_reg, TCB_OFF_IRQ_STAT) && w_strb_reg[0]) ? w_data_reg[TCB_EV_W-1:0] : '0;
        // a new event beats a clear in the same cycle
        irq_stat_next = (irq_stat_reg & ~irq_clr) | ev;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= TCB_ST_IDLE;
            wr_ptr_reg <= 14'h0;
            trig_ptr_reg <= 14'h0;
            pre_cnt_reg <= 14'h0;
            post_trigger_count_reg <= 14'h0;
            loop_cnt_reg <= 16'h0;
            triggered_reg <= 1'b0;
            loop_done_reg <= 1'b0;
            cond_a_hit_reg <= 1'b0;
            cond_b_hit_reg <= 1'b0;
            emu_run_d_reg <= 1'b0;
            irq_stat_reg <= '0;
            irq <= 1'b0;
            capture_active <= 1'b0;
        end else begin
            state_reg <= state_next;
            wr_ptr_reg <= wr_ptr_next;
            trig_ptr_reg <= trig_ptr_next;
            pre_cnt_reg <= pre_cnt_next;
            post_trigger_count_reg <= post_trigger_count_next;
            loop_cnt_reg <= loop_cnt_next;
            triggered_reg <= triggered_next;
            loop_done_reg <= loop_done_next;
            cond_a_hit_reg <= cond_a_hit_next;
            cond_b_hit_reg <= cond_b_hit_next;
            emu_run_d_reg <= emu_run;
            irq_stat_reg <= irq_stat_next;
            irq <= |(irq_stat_next & irq_mask_reg);
            capture_active <= (state_next == TCB_ST_PRE) || (state_next == TCB_ST_POST);
        end
    end

    // frame index is signed around the trigger; reading while capturing gives a moving target
    tcb_frame_ram u_ram (
        .aclk(aclk),
        .wr_en(store && state_next != TCB_ST_STOP),
        .wr_addr(wr_ptr_reg),
        .wr_data(cur_frame),
        .rd_addr((trig_ptr_reg + frame_sel_reg[13:0]) & mask),
        .rd_data(rd_frame)
    );

    always_comb begin
        rd_hit = 1'b1;
        unique case (1'b1)
            hit(ar_addr, TCB_OFF_CTRL): rd_mux = {28'h0, small_cfg_reg, 3'h0};
            hit(ar_addr, TCB_OFF_STATUS): rd_mux = {19'h0, state_reg, 3'h0, (state_reg == TCB_ST_DONE),
                loop_done_reg | (state_reg == TCB_ST_STOP), triggered_reg, cond_b_hit_reg, cond_a_hit_reg};
            hit(ar_addr, TCB_OFF_POST_SET): rd_mux = {18'h0, post_trigger_setting_reg};
            hit(ar_addr, TCB_OFF_LOOP_SET): rd_mux = {16'h0, loop_setting_reg};
            hit(ar_addr, TCB_OFF_POST_CNT): rd_mux = {18'h0, post_trigger_count_reg};
            hit(ar_addr, TCB_OFF_PRE_CNT): rd_mux = {18'h0, pre_cnt_reg};
            hit(ar_addr, TCB_OFF_LOOP_CNT): rd_mux = {16'h0, loop_cnt_reg};
            hit(ar_addr, TCB_OFF_FRAME_SEL): rd_mux = {16'h0, frame_sel_reg};
            hit(ar_addr, TCB_OFF_FRAME_LO): rd_mux = {3'h0, rd_frame.int_level, rd_frame.cycle_type_tag,
                rd_frame.data, rd_frame.addr};
            hit(ar_addr, TCB_OFF_FRAME_HI): rd_mux = {12'h0, rd_frame.extra_probe_b, rd_frame.extra_probe_a,
                rd_frame.sync_probe_b, rd_frame.sync_probe_a, rd_frame.third_io_port_state,
                rd_frame.first_io_port_state};
            hit(ar_addr, TCB_OFF_IRQ_STAT): rd_mux = {27'h0, irq_stat_reg};
            hit(ar_addr, TCB_OFF_IRQ_MASK): rd_mux = {27'h0, irq_mask_reg};
            default: begin
                rd_mux = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
        wr_hit = hit(aw_addr_reg, TCB_OFF_CTRL) | hit(aw_addr_reg, TCB_OFF_POST_SET)
            | hit(aw_addr_reg, TCB_OFF_LOOP_SET) | hit(aw_addr_reg, TCB_OFF_FRAME_SEL)
            | hit(aw_addr_reg, TCB_OFF_IRQ_STAT) | hit(aw_addr_reg, TCB_OFF_IRQ_MASK);
    end
endmodule

// *** logic/tcb_pkg.sv ***
package tcb_pkg;

    // buffer geometry: full 16K frames, smaller configuration 4K frames
    localparam int TCB_PTR_W = 14;
    localparam int TCB_DEPTH = 16384;
    localparam logic [13:0] TCB_MASK_FULL = 14'h3fff;
    localparam logic [13:0] TCB_MASK_SMALL = 14'h0fff;
    localparam logic [13:0] TCB_POST_DEFAULT = 14'h2000;
    localparam logic [15:0] TCB_LOOP_DEFAULT = 16'h0000;

    // register byte offsets
    localparam int TCB_AXI_AW = 8;
    localparam logic [7:0] TCB_OFF_CTRL = 8'h00;
    localparam logic [7:0] TCB_OFF_STATUS = 8'h04;
    localparam logic [7:0] TCB_OFF_POST_SET = 8'h08;
    localparam logic [7:0] TCB_OFF_LOOP_SET = 8'h0c;
    localparam logic [7:0] TCB_OFF_POST_CNT = 8'h10;
    localparam logic [7:0] TCB_OFF_PRE_CNT = 8'h14;
    localparam logic [7:0] TCB_OFF_LOOP_CNT = 8'h18;
    localparam logic [7:0] TCB_OFF_FRAME_SEL = 8'h1c;
    localparam logic [7:0] TCB_OFF_FRAME_LO = 8'h20;
    localparam logic [7:0] TCB_OFF_FRAME_HI = 8'h24;
    localparam logic [7:0] TCB_OFF_IRQ_STAT = 8'h28;
    localparam logic [7:0] TCB_OFF_IRQ_MASK = 8'h2c;

    // control register bits
    localparam int TCB_CTRL_STOP = 0;
    localparam int TCB_CTRL_RESUME = 1;
    localparam int TCB_CTRL_ESCAPE = 2;
    localparam int TCB_CTRL_SMALL = 3;

    // event / status bit positions
    localparam int TCB_EV_W = 5;
    localparam int TCB_EV_COND_A = 0;
    localparam int TCB_EV_COND_B = 1;
    localparam int TCB_EV_TRIG = 2;
    localparam int TCB_EV_STOP = 3;
    localparam int TCB_EV_DONE = 4;
    localparam int TCB_STAT_STATE_LSB = 8;

    localparam logic [1:0] TCB_RESP_OKAY = 2'h0;
    localparam logic [1:0] TCB_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        TCB_CYC_NONE = 2'h0,
        TCB_CYC_FETCH = 2'h1,
        TCB_CYC_WRITE = 2'h2,
        TCB_CYC_READ = 2'h3
    } tcb_cyc_e;

    typedef enum logic [4:0] {
        TCB_ST_IDLE = 5'h01,
        TCB_ST_PRE = 5'h02,
        TCB_ST_POST = 5'h04,
        TCB_ST_STOP = 5'h08,
        TCB_ST_DONE = 5'h10
    } tcb_state_e;

    typedef struct packed {
        logic extra_probe_b;
        logic extra_probe_a;
        logic sync_probe_b;
        logic sync_probe_a;
        logic [7:0] third_io_port_state;
        logic [7:0] first_io_port_state;
        logic [2:0] int_level;
        tcb_cyc_e cycle_type_tag;
        logic [7:0] data;
        logic [15:0] addr;
    } tcb_frame_s;

    localparam int TCB_FRAME_W = $bits(tcb_frame_s);

endpackage

// *** logic/tcb_frame_ram.sv ***
`timescale 1ns/100ps
module tcb_frame_ram
    import tcb_pkg::*;
(
    input wire logic aclk,
    input wire logic wr_en,
    input wire logic [TCB_PTR_W-1:0] wr_addr,
    input wire tcb_frame_s wr_data,
    input wire logic [TCB_PTR_W-1:0] rd_addr,
    output tcb_frame_s rd_data
);
    tcb_frame_s mem [TCB_DEPTH];

    // no reset: plain block ram, read data registered
    always_ff @(posedge aclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// *** sim/tcb_core_model.sv ***
`timescale 1ns/100ps
module tcb_core_model
(
    input wire logic aclk,
    input wire logic go,
    output logic cyc_valid,
    output logic [15:0] cyc_addr
);
    // one bus cycle per clock while go is high; the address steps per cycle so every frame is traceable
    initial cyc_valid = 1'b0;
    initial cyc_addr = 16'h0000;
    always @(posedge aclk) begin
        cyc_valid <= go;
        cyc_addr <= cyc_addr + 16'(cyc_valid);
    end
endmodule

// *** sim/tcb_trace_monitor.sv ***
`timescale 1ns/100ps
module tcb_trace_monitor
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic emu_run,
    input wire logic break_in,
    input wire logic capture_active,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    wire hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    start_cap_a: assert property ($rose(emu_run) |-> ##[1:3] capture_active) else $error("no start");
    cap_cause_a: assert property ($rose(capture_active) |-> emu_run) else $error("stray start");
    break_stop_a: assert property (break_in && capture_active |-> ##[1:3] !capture_active)
        else $error("no stop");
    wr_resp_a: assert property (hs |=> !s_axi_awready ##1 s_axi_bvalid) else $error("no write answer");
    wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write stuck");
    wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready early");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("no read answer");
    rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read stuck");
    cover property ($rose(emu_run));
    cover property ($fell(capture_active));
    cover property (hs);
endmodule
bind tcb_trace_capture tcb_trace_monitor i_tcb_trace_monitor (.aclk, .aresetn, .emu_run, .break_in, .capture_active,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

// *** sim/testbench.sv ***
`timescale 1ns/100ps
module testbench
    import tcb_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, emu_run = 1'b0, go = 1'b0, trig_in = 1'b0, cond_in = 1'b0, break_in = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, capture_active, irq, cyc_valid;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [15:0] cyc_addr, k;
    logic [3:0] pr = 4'ha;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int err_count = 0, check_count = 0, sel[3] = '{-3, 0, 4};
    always #5 aclk = ~aclk;
    tcb_core_model i_tcb_core_model (.aclk, .go, .cyc_valid, .cyc_addr);
    // frame fields follow the address, so any stored frame can be predicted; probes held steady past the sync delay
    tcb_trace_capture i_tcb_trace_capture (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .emu_run, .cyc_valid, .cyc_type(tcb_cyc_e'(cyc_addr[1:0])), .cyc_addr, .cyc_data(~cyc_addr[7:0]),
        .int_level(cyc_addr[4:2]), .first_io_port_state(cyc_addr[7:0]), .third_io_port_state(cyc_addr[15:8]),
        .sync_probe_a(pr[0]), .sync_probe_b(pr[1]), .extra_probe_a(pr[2]), .extra_probe_b(pr[3]), .trig_in,
        .cond_a_in(cond_in), .cond_b_in(cond_in), .break_in, .capture_active, .irq);
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
    endtask
    task automatic run(input int n);
        @(posedge aclk);
        go <= 1'b1;
        repeat (n) @(posedge aclk);
        go <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (10000) @(posedge aclk);
        err_count++;
        close_out;
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(TCB_OFF_STATUS, 32'h0000_0100);
        rd(TCB_OFF_POST_SET, 32'h0000_2000);
        rd(8'h30, 32'h0);
        chk(32'(s_axi_rresp), 32'(TCB_RESP_SLVERR));
        wr(8'h30, 32'h0);
        chk(32'(s_axi_bresp), 32'(TCB_RESP_SLVERR));
        wr(TCB_OFF_POST_SET, 32'h4);
        chk(32'(s_axi_bresp), 32'(TCB_RESP_OKAY));
        wr(TCB_OFF_IRQ_MASK, 32'h10);
        emu_run <= 1'b1;
        run(10);
        rd(TCB_OFF_PRE_CNT, 32'ha);
        trig_in <= 1'b1;
        run(1);
        trig_in <= 1'b0;
        run(7);
        rd(TCB_OFF_POST_CNT, 32'h4);
        rd(TCB_OFF_LOOP_CNT, 32'h1);
        rd(TCB_OFF_STATUS, 32'h0000_101c);
        chk(32'(irq), 32'h1);
        foreach (sel[i]) begin
            k = 16'(10 + sel[i]);
            wr(TCB_OFF_FRAME_SEL, 32'(sel[i]));
            repeat (2) @(posedge aclk);
            rd(TCB_OFF_FRAME_LO, {3'h0, k[4:2], k[1:0], ~k[7:0], k});
            rd(TCB_OFF_FRAME_HI, {12'h000, pr, k});
        end
        wr(TCB_OFF_IRQ_STAT, 32'h1f);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h0);
        $display("test capture and trigger done");
        emu_run <= 1'b0;
        @(posedge aclk) emu_run <= 1'b1;
        cond_in <= 1'b1;
        run(5);
        cond_in <= 1'b0;
        chk(32'(capture_active), 32'h1);
        wr(TCB_OFF_CTRL, 32'h1);
        run(3);
        rd(TCB_OFF_PRE_CNT, 32'h5);
        rd(TCB_OFF_STATUS, 32'h0000_080b);
        wr(TCB_OFF_CTRL, 32'h2);
        run(3);
        rd(TCB_OFF_PRE_CNT, 32'h8);
        break_in <= 1'b1;
        @(posedge aclk) break_in <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(32'(capture_active), 32'h0);
        $display("test stop and resume done");
        wr(TCB_OFF_CTRL, 32'h8);
        // frame select still 4: index 4 must hold frame 4100 after the 4K wrap
        k = cyc_addr + 16'h1004;
        emu_run <= 1'b0;
        @(posedge aclk) emu_run <= 1'b1;
        run(4101);
        rd(TCB_OFF_PRE_CNT, 32'hfff);
        rd(TCB_OFF_FRAME_LO, {3'h0, k[4:2], k[1:0], ~k[7:0], k});
        $display("test small buffer wrap done");
        close_out;
    end
endmodule
